// file: verilog/pt3_consts.svh
// Purpose: Offsets, field positions, reset values and line masks of the port 3 block
// Assumes: Included by bare name from design files
// Notes:   Definitions only
`ifndef PT3_CONSTS_SVH
`define PT3_CONSTS_SVH

`define PT3_ADDR_W            16
`define PT3_DATA_OFS          16'hFFC4
`define PT3_DIR_OFS           16'hFFC6
`define PT3_OD_OFS            16'hF1C6
`define PT3_PININ_OFS         16'hF1C8
`define PT3_RESET_VAL         16'h0000
`define PT3_DATA_MASK         16'hFFFF
`define PT3_DIR_MASK          16'hFFFF
`define PT3_OD_MASK           16'h2FFF
`define PT3_PIN_MASK          16'hBFFF
`define PT3_LINE_STROBE       12
`define PT3_LINE_NOPIN        14
`define PT3_LINE_SYSTEM_CLOCK_OUT       15

`endif

// file: verilog/pt3_pkg.sv
// Purpose: Types shared by the port 3 block
// Assumes: Nothing
// Notes:   Constants live in pt3_consts.svh
package pt3_pkg;
  typedef logic [15:0] pt3_word_t;
  typedef enum logic [1:0] {PT3_SEL_NONE, PT3_SEL_DATA, PT3_SEL_DIR, PT3_SEL_OD} pt3_sel_t;
endpackage

// file: verilog/pt3_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for the pin inputs
// Assumes: Inputs asynchronous to clk_i
// Notes:   Stage one feeds stage two only
`timescale 1ns/10ps
module pt3_sync (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic [15:0] async_i,
  output logic      [15:0] sync_o
);
  logic [15:0] s1_ff;
  logic [15:0] s2_ff;
  logic [15:0] s3_ff;
  logic [15:0] out_ff;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s1_ff <= 16'h0000;
      s2_ff <= 16'h0000;
      s3_ff <= 16'h0000;
    end else begin
      s1_ff <= async_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // A bit changes only once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      out_ff <= 16'h0000;
    end else begin
      out_ff <= (s2_ff & s3_ff) | (out_ff & (s2_ff | s3_ff));
    end
  end

  assign sync_o = out_ff;
endmodule // pt3_sync

// file: verilog/pt3_regs.sv
// Purpose: Data, direction and open-drain registers with read port
// Assumes: One-cycle strobes, never both at once
// Notes:   Read data stand only in the cycle after the read strobe
`timescale 1ns/10ps
`include "pt3_consts.svh"
module pt3_regs (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [15:0] pin_level_i,
  output logic      [15:0] rdata_o,
  output logic      [15:0] data_o,
  output logic      [15:0] dir_o,
  output logic      [15:0] od_o
);
  logic [15:0] data_ff;
  logic [15:0] dir_ff;
  logic [15:0] od_ff;
  logic [15:0] rdata_ff;

  function automatic pt3_pkg::pt3_sel_t decode(input logic [15:0] a);
    if (a == `PT3_DATA_OFS) decode = pt3_pkg::PT3_SEL_DATA;
    else if (a == `PT3_DIR_OFS) decode = pt3_pkg::PT3_SEL_DIR;
    else if (a == `PT3_OD_OFS) decode = pt3_pkg::PT3_SEL_OD;
    else decode = pt3_pkg::PT3_SEL_NONE;
  endfunction

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      data_ff <= `PT3_RESET_VAL;
    end else if (wr_i && decode(addr_i) == pt3_pkg::PT3_SEL_DATA) begin
      data_ff <= wdata_i & `PT3_DATA_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      dir_ff <= `PT3_RESET_VAL;
    end else if (wr_i && decode(addr_i) == pt3_pkg::PT3_SEL_DIR) begin
      dir_ff <= wdata_i & `PT3_DIR_MASK;
    end
  end

  // Lines 15, 14 and 12 have no open-drain bit; they read zero
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      od_ff <= `PT3_RESET_VAL;
    end else if (wr_i && decode(addr_i) == pt3_pkg::PT3_SEL_OD) begin
      od_ff <= wdata_i & `PT3_OD_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rdata_ff <= 16'h0000;
    end else if (rd_i) begin
      if (decode(addr_i) == pt3_pkg::PT3_SEL_DATA) rdata_ff <= data_ff;
      else if (decode(addr_i) == pt3_pkg::PT3_SEL_DIR) rdata_ff <= dir_ff;
      else if (decode(addr_i) == pt3_pkg::PT3_SEL_OD) rdata_ff <= od_ff;
      else if (addr_i == `PT3_PININ_OFS) rdata_ff <= pin_level_i;
      else rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= 16'h0000;
    end
  end

  assign rdata_o = rdata_ff;
  assign data_o  = data_ff;
  assign dir_o   = dir_ff;
  assign od_o    = od_ff;
endmodule // pt3_regs

// file: verilog/pt3_port.sv
// Purpose: Port 3 general purpose I/O with alternate function merging
// Assumes: Peripherals hold alternate outputs high when unused
// Notes:   Pin drive is registered, one edge after the control changes
//
// How it works
// - Fifteen usable lines held in sixteen-bit data, direction and drain registers.
// - Direction zero floats the line; direction one drives it.
// - Drain bit zero gives push-pull, one gives open-drain.
// - Lines 15, 14 and 12 never drive open-drain; bits absent.
// - Data bit 14 is stored but drives no pin.
// - Alternate inputs receive the synchronised pin level.
// - Alternate output is ANDed with the data latch before the pin.
// - Unused alternate outputs rest high, leaving plain output undisturbed.
// - Bidirectional functions follow peripheral mode; software sets direction to match.
// - Inputs 0,2,4-7; outputs 1,3,10,12,15; bidirectional 8,9,11,13.
// - Clock output enable forces the line 15 driver on.
// - Line 12 takes the strobe function after reset from start-up configuration.
// - Line 12 is plain I/O when byte-high disable is one and write config zero.
// - Strobe function forces the line 12 driver on.
// - During bus hold line 12 uses only its direction and latch bits.
`timescale 1ns/10ps
`include "pt3_consts.svh"
module pt3_port (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire logic [15:0] pin_i,
  output logic      [15:0] pin_o,
  output logic      [15:0] pin_oe_o,
  input  wire logic        timer_six_toggle_out_i,
  input  wire logic        timer_three_toggle_out_i,
  input  wire logic        async_serial_tx_i,
  input  wire logic        byte_high_enable_strobe_i,
  input  wire logic        write_high_strobe_i,
  input  wire logic        system_clock_out_i,
  input  wire logic        system_clock_out_en_i,
  input  wire logic        byte_high_disable_i,
  input  wire logic        write_strobe_config_i,
  input  wire logic        bus_hold_i,
  input  wire logic        sync_master_rx_slave_tx_out_i,
  input  wire logic        sync_master_tx_slave_rx_out_i,
  input  wire logic        async_serial_rx_out_i,
  input  wire logic        sync_shift_clock_out_i,
  output logic             capture_timer_zero_count_in_o,
  output logic             timer_block_capture_in_o,
  output logic             timer_three_updown_in_o,
  output logic             timer_four_count_in_o,
  output logic             timer_three_count_in_o,
  output logic             timer_two_count_in_o,
  output logic             sync_master_rx_slave_tx_in_o,
  output logic             sync_master_tx_slave_rx_in_o,
  output logic             async_serial_rx_in_o,
  output logic             sync_shift_clock_in_o
);
  pt3_pkg::pt3_word_t data_w;
  pt3_pkg::pt3_word_t dir_w;
  pt3_pkg::pt3_word_t od_w;
  pt3_pkg::pt3_word_t in_level;
  pt3_pkg::pt3_word_t alt_out;
  pt3_pkg::pt3_word_t force_en;
  pt3_pkg::pt3_word_t nxt_level;
  pt3_pkg::pt3_word_t nxt_oe;
  logic [15:0]        level_ff;
  logic [15:0]        oe_ff;
  logic               strobe_on;
  logic               strobe_val;

  pt3_regs u_regs (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .addr_i      (addr_i),
    .wdata_i     (wdata_i),
    .wr_i        (wr_i),
    .rd_i        (rd_i),
    .pin_level_i (in_level),
    .rdata_o     (rdata_o),
    .data_o      (data_w),
    .dir_o       (dir_w),
    .od_o        (od_w)
  );

  pt3_sync u_sync (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .async_i (pin_i),
    .sync_o  (in_level)
  );

  // Alternate inputs read the filtered pin level
  assign capture_timer_zero_count_in_o = in_level[0];
  assign timer_block_capture_in_o      = in_level[2];
  assign timer_three_updown_in_o       = in_level[4];
  assign timer_four_count_in_o         = in_level[5];
  assign timer_three_count_in_o        = in_level[6];
  assign timer_two_count_in_o          = in_level[7];
  assign sync_master_rx_slave_tx_in_o  = in_level[8];
  assign sync_master_tx_slave_rx_in_o  = in_level[9];
  assign async_serial_rx_in_o          = in_level[11];
  assign sync_shift_clock_in_o         = in_level[13];

  // Strobe owns line 12 unless disabled or the bus is held
  assign strobe_on  = !(byte_high_disable_i && !write_strobe_config_i) && !bus_hold_i;
  assign strobe_val = write_strobe_config_i ? write_high_strobe_i : byte_high_enable_strobe_i;

  // Unused alternate outputs are expected high, so AND leaves the latch alone
  always_comb begin
    alt_out     = 16'hFFFF;
    alt_out[1]  = timer_six_toggle_out_i;
    alt_out[3]  = timer_three_toggle_out_i;
    alt_out[8]  = sync_master_rx_slave_tx_out_i;
    alt_out[9]  = sync_master_tx_slave_rx_out_i;
    alt_out[10] = async_serial_tx_i;
    alt_out[11] = async_serial_rx_out_i;
    alt_out[13] = sync_shift_clock_out_i;
    alt_out[15] = system_clock_out_en_i ? system_clock_out_i : 1'b1;
    force_en     = 16'h0000;
    force_en[`PT3_LINE_SYSTEM_CLOCK_OUT] = system_clock_out_en_i;
    force_en[`PT3_LINE_STROBE] = strobe_on;
  end

  // Drive level and enable per line, then registered
  always_comb begin
    nxt_level = data_w & alt_out;
    nxt_level[`PT3_LINE_STROBE] = strobe_on ? strobe_val : data_w[`PT3_LINE_STROBE];
    nxt_oe = dir_w | force_en;
    // Open-drain only drives low; a one releases the pin
    nxt_oe = nxt_oe & ~(od_w & `PT3_OD_MASK & nxt_level);
    nxt_oe = nxt_oe & `PT3_PIN_MASK;
    nxt_level = nxt_level & `PT3_PIN_MASK;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      level_ff <= 16'h0000;
    end else begin
      level_ff <= nxt_level;
    end
  end

  // Line 12 enable comes up at the first edge after release, strobe selected
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      oe_ff <= 16'h0000;
    end else begin
      oe_ff <= nxt_oe;
    end
  end

  assign pin_o    = level_ff;
  assign pin_oe_o = oe_ff;
endmodule // pt3_port

// file: dv/pt3_pin_model.sv
// Purpose: Pads and outside world seen by port 3
// Assumes: Outside source ext_i set by the bench
// Notes:   Released lines show the outside level, not the last drive
`timescale 1ns/10ps
module pt3_pin_model (
  input  wire logic [15:0] drv_i,
  input  wire logic [15:0] oe_i,
  input  wire logic [15:0] ext_i,
  output logic      [15:0] lvl_o
);
  // Driven lines read back their own level
  assign lvl_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule // pt3_pin_model

// file: dv/pt3_port_assertions.sv
// Purpose: Port-level checks of pt3_port
// Assumes: Bound to pt3_port
// Notes:   Pin drive lags a register write by two edges
`timescale 1ns/10ps
`include "pt3_consts.svh"
module pt3_port_assertions (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic [15:0] pin_i,
  input wire logic [15:0] pin_o,
  input wire logic [15:0] pin_oe_o,
  input wire logic        timer_six_toggle_out_i,
  input wire logic        system_clock_out_en_i,
  input wire logic        byte_high_disable_i,
  input wire logic        write_strobe_config_i,
  input wire logic        bus_hold_i,
  input wire logic        timer_block_capture_in_o
);
  logic strobe_req;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Strobe owns line 12 unless disabled or the bus is held
  assign strobe_req = !(byte_high_disable_i && !write_strobe_config_i) && !bus_hold_i;
  sequence s_dir_wr;
    wr_i && addr_i == `PT3_DIR_OFS ##1 !(wr_i && addr_i == `PT3_DIR_OFS);
  endsequence
  sequence s_dat_wr;
    wr_i && addr_i == `PT3_DATA_OFS ##1 !(wr_i && addr_i == `PT3_DATA_OFS);
  endsequence
  a_line14_quiet: assert property (pin_o[14] == 1'h0 && pin_oe_o[14] == 1'h0)
    else $error("line 14 driven");
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data outside read slot");
  // Reset in the window keeps the first edge after release, when enables are still zero, out of the check
  a_system_clock_out_drive: assert property ((rstn_i && system_clock_out_en_i) [*2] |-> pin_oe_o[15])
    else $error("clock line driver off");
  a_strobe_drive: assert property ((rstn_i && strobe_req) [*2] |-> pin_oe_o[12])
    else $error("strobe line driver off");
  a_dir_to_pin: assert property (s_dir_wr |=>
    pin_oe_o[15] == ($past(wdata_i[15], 2) | $past(system_clock_out_en_i)))
    else $error("direction write not on pin");
  a_data_to_pin: assert property (s_dat_wr |=> pin_o[0] == $past(wdata_i[0], 2))
    else $error("data write not on pin");
  a_alt_and: assert property (!timer_six_toggle_out_i |=> !pin_o[1])
    else $error("alternate output not gated");
  a_alt_input: assert property ($stable(pin_i[2]) [*6] |-> timer_block_capture_in_o == pin_i[2])
    else $error("alternate input lags pin");
endmodule // pt3_port_assertions

// file: dv/pt3_port_bench.sv
// Purpose: Self-checking bench of pt3_port
// Assumes: 10 MHz clock, synchronous active-low reset
// Notes:   Alternate outputs rest high unless a test pulls one low
`timescale 1ns/10ps
`include "pt3_consts.svh"
module pt3_port_bench;
  typedef struct packed {logic [15:0] a; logic [15:0] d; logic [15:0] e;} pt3_row_t;
  logic        clk_i = 1'h0;
  logic        rstn_i = 1'h0;
  logic        wr = 1'h0;
  logic        rd = 1'h0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] ext = 16'h0000;
  logic [9:0]  alt = 10'h3FF;
  logic [3:0]  ctl = 4'h2;
  logic [15:0] rdata, pin_o, pin_oe, pin_i;
  logic [9:0]  ins;
  int          fail_count = 0;
  int          samples_checked = 0;
  pt3_row_t    rows [4] = '{'{`PT3_DATA_OFS, 16'hFFFF, 16'hFFFF}, '{`PT3_DIR_OFS, 16'hA5A5, 16'hA5A5},
                            '{`PT3_OD_OFS, 16'hFFFF, 16'h2FFF}, '{16'h1234, 16'hFFFF, 16'h0000}};
  always #50 clk_i = ~clk_i;
  pt3_port u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe), .timer_six_toggle_out_i(alt[0]),
    .timer_three_toggle_out_i(alt[1]), .async_serial_tx_i(alt[2]), .byte_high_enable_strobe_i(alt[3]),
    .write_high_strobe_i(alt[4]), .system_clock_out_i(alt[5]), .system_clock_out_en_i(ctl[0]),
    .byte_high_disable_i(ctl[1]), .write_strobe_config_i(ctl[2]), .bus_hold_i(ctl[3]),
    .sync_master_rx_slave_tx_out_i(alt[6]), .sync_master_tx_slave_rx_out_i(alt[7]),
    .async_serial_rx_out_i(alt[8]), .sync_shift_clock_out_i(alt[9]), .capture_timer_zero_count_in_o(ins[0]),
    .timer_block_capture_in_o(ins[1]), .timer_three_updown_in_o(ins[2]), .timer_four_count_in_o(ins[3]),
    .timer_three_count_in_o(ins[4]), .timer_two_count_in_o(ins[5]), .sync_master_rx_slave_tx_in_o(ins[6]),
    .sync_master_tx_slave_rx_in_o(ins[7]), .async_serial_rx_in_o(ins[8]), .sync_shift_clock_in_o(ins[9]));
  pt3_pin_model u_pins (.drv_i(pin_o), .oe_i(pin_oe), .ext_i(ext), .lvl_o(pin_i));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk_i);
    wr <= 1'h0;
  endtask
  task automatic rd_reg(input logic [15:0] a, input logic [15:0] e);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk_i);
    rd <= 1'h0;
    #1 chk(rdata, e);
  endtask
  task automatic settle();
    repeat (6) @(posedge clk_i);
    #1;
  endtask
  task automatic test_done();
    $display("checked %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk_i);
    fail_count++;
    test_done();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'h1;
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, rows[i].e);
    end
    $display("test registers end");
    wr_reg(`PT3_OD_OFS, 16'h0000);
    wr_reg(`PT3_DATA_OFS, 16'h5A5A);
    wr_reg(`PT3_DIR_OFS, 16'hFFFF);
    settle();
    chk(pin_oe, 16'hBFFF);
    chk(pin_o, 16'h1A5A);
    wr_reg(`PT3_OD_OFS, 16'hFFFF);
    settle();
    chk(pin_oe, 16'hB5A5);
    @(posedge clk_i);
    alt[0] <= 1'h0;
    settle();
    chk(pin_o, 16'h1A58);
    @(posedge clk_i);
    alt <= 10'h000;
    settle();
    chk(pin_o, 16'h1050);
    // Byte-high source stays low from here so the strobe source select is visible
    @(posedge clk_i);
    alt <= 10'h3F7;
    $display("test drive end");
    wr_reg(`PT3_DIR_OFS, 16'h0000);
    ctl <= 4'h1;
    settle();
    chk(pin_oe, 16'h9000);
    chk(pin_o, 16'h0A5A);
    @(posedge clk_i);
    ctl <= 4'h9;
    settle();
    chk(pin_oe, 16'h8000);
    chk(pin_o, 16'h1A5A);
    @(posedge clk_i);
    ext <= 16'h0055;
    settle();
    chk({6'h00, ins}, 16'h0017);
    rd_reg(`PT3_PININ_OFS, 16'h0055);
    @(posedge clk_i);
    ext <= 16'h2B00;
    settle();
    chk({6'h00, ins}, 16'h03C0);
    $display("test alternate end");
    @(posedge clk_i);
    ctl <= 4'h4;
    rstn_i <= 1'h0;
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    #1 chk(pin_oe, 16'h1000);
    chk(pin_o, 16'h1000);
    rd_reg(`PT3_DATA_OFS, 16'h0000);
    rd_reg(`PT3_DIR_OFS, 16'h0000);
    rd_reg(`PT3_OD_OFS, 16'h0000);
    $display("test reset end");
    test_done();
  end
endmodule // pt3_port_bench
bind pt3_port pt3_port_assertions u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
  .timer_six_toggle_out_i(timer_six_toggle_out_i), .system_clock_out_en_i(system_clock_out_en_i),
  .byte_high_disable_i(byte_high_disable_i), .write_strobe_config_i(write_strobe_config_i),
  .bus_hold_i(bus_hold_i), .timer_block_capture_in_o(timer_block_capture_in_o));
